/* File: hw/flash_host_ctrl.v */
// Host-side controller driving a banked parallel flash over its pins.
// Assumes software loads a cycle list, then starts it; device pins asynchronous.
// Contract
// - Address latched late fall, data early rise
// - Host writes all cycles except reads
// - Autoselect or timeout left by reset
// - Same bank held during autoselect reads
// - Device identifier read over three cycles
// - Bypass program needs prior bypass entry
// - Suspend only during sector erase
// - Extra sectors are single select/30 cycles
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_map.vh"
module flash_host_ctrl (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRData,
  output reg  [21:0] flashAddr,
  input  wire [15:0] flashDqIn,
  output reg  [15:0] flashDqOut,
  output reg         flashDqOe_b,
  output reg         flashWe_b,
  output reg         flashOe_b,
  output reg         flashCe_b,
  input  wire        readyBusy_n
);
  localparam S_IDLE = 3'd0, S_LOAD = 3'd1, S_SETUP = 3'd2, S_STROBE = 3'd3,
             S_HOLD = 3'd4, S_POLL = 3'd5, S_NEXT = 3'd6;
  localparam integer SETUP_N  = `SETUP_CYC;   // Cut to the 3-bit counter where used
  localparam integer STROBE_N = `STROBE_CYC;

  reg [2:0]  state_q;
  reg [15:0] ctrl_q;
  reg [21:0] addr_q;
  reg [15:0] wdata_q;
  reg [15:0] rdata_q;
  reg [2:0]  seqIdx_q;
  reg [2:0]  step_q;
  reg [2:0]  cnt_q;
  reg        done_q;
  reg        fail_q;
  reg        havePrev_q;
  reg        prevTog_q;
  reg        pollMode_q;   // Status reads repeated at the last location
  reg        toSeen_q;     // Timeout flag seen on the previous toggling pair
  reg [15:0] dqSync1_q, dqSync2_q;
  reg        rdySync1_q, rdySync2_q;
  wire [21:0] seqAddr;
  wire [15:0] seqData;

  // Command cycle memory; software writes entries, engine reads them.
  // Bypass, suspend and added-sector cycles are plain entries here
  seq_store u_seq (
    .clk    (clk),
    .wrEn   (regWr && regAddr == `REG_SEQ_DATA),
    .wrIdx  (seqIdx_q),
    .wrAddr (addr_q),
    .wrData (regWData),
    .rdIdx  (step_q),
    .rdAddr (seqAddr),
    .rdData (seqData)
  );

  // Cycle is a read when its read-mask bit is set (autoselect ID reads)
  function isRead;
    input [5:0] mask;
    input [2:0] idx;
    reg   [7:0] wide;
    begin
      // Steps 6 and 7 have no mask bit and are always writes
      wide   = {2'b00, mask};
      isRead = wide[idx];
    end
  endfunction

  wire [2:0] lastStep = ctrl_q[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
  wire       curRead  = pollMode_q | isRead(ctrl_q[`CTRL_RDMASK_MSB:`CTRL_RDMASK_LSB], step_q);
  wire       busy     = (state_q != S_IDLE);

  // Two-flop synchronisers on device outputs; logic reads only the second
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dqSync1_q  <= 16'h0000;
      dqSync2_q  <= 16'h0000;
      rdySync1_q <= 1'b1;
      rdySync2_q <= 1'b1;
    end else begin
      dqSync1_q  <= flashDqIn;
      dqSync2_q  <= dqSync1_q;
      rdySync1_q <= readyBusy_n;
      rdySync2_q <= rdySync1_q;
    end
  end

  // Software registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q   <= `CTRL_RST;
      addr_q   <= 22'h000000;
      wdata_q  <= 16'h0000;
      seqIdx_q <= 3'h0;
    end else if (regWr) begin
      if (regAddr == `REG_CTRL) begin
        ctrl_q <= regWData;
      end else if (regAddr == `REG_ADDR) begin
        addr_q[15:0] <= regWData;
      end else if (regAddr == `REG_SEQ_ADDR) begin
        // Upper bits apart, so bank and sector select stay free of the low word
        addr_q[21:16] <= regWData[5:0];
      end else if (regAddr == `REG_WDATA) begin
        wdata_q <= regWData;
      end else if (regAddr == `REG_SEQ_IDX) begin
        seqIdx_q <= regWData[2:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRData <= 16'h0000;
    end else if (regRd) begin
      if (regAddr == `REG_CTRL) begin
        regRData <= ctrl_q;
      end else if (regAddr == `REG_WDATA) begin
        regRData <= wdata_q;
      end else if (regAddr == `REG_SEQ_ADDR) begin
        regRData <= {10'h000, addr_q[21:16]};
      end else if (regAddr == `REG_STATUS) begin
        regRData <= {12'h000, rdySync2_q, fail_q, done_q, busy};
      end else if (regAddr == `REG_RDATA) begin
        regRData <= rdata_q;
      end else if (regAddr == `REG_SEQ_IDX) begin
        regRData <= {13'h0000, seqIdx_q};
      end else begin
        regRData <= 16'h0000;
      end
    end else begin
      regRData <= 16'h0000;
    end
  end

  // Bus cycle engine: one pin cycle per sequence entry, then optional polling
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= S_IDLE;
      step_q      <= 3'h0;
      cnt_q       <= 3'h0;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      rdata_q     <= 16'h0000;
      havePrev_q  <= 1'b0;
      prevTog_q   <= 1'b0;
      pollMode_q  <= 1'b0;
      toSeen_q    <= 1'b0;
      flashAddr   <= 22'h000000;
      flashDqOut  <= 16'h0000;
      flashDqOe_b <= 1'b1;
      flashWe_b   <= 1'b1;
      flashOe_b   <= 1'b1;
      flashCe_b   <= 1'b1;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (regWr && regAddr == `REG_CTRL && regWData[`CTRL_GO]) begin
            state_q    <= S_LOAD;
            step_q     <= 3'h0;
            done_q     <= 1'b0;
            fail_q     <= 1'b0;
            havePrev_q <= 1'b0;
            pollMode_q <= 1'b0;
            toSeen_q   <= 1'b0;
          end
        end
        S_LOAD: begin
          // Memory output is registered; wait one cycle for the entry
          state_q <= S_SETUP;
          cnt_q   <= SETUP_N[2:0];
        end
        S_SETUP: begin
          // Address and CE settle before the strobe falls; the device latches
          // the address on the later falling edge, here the strobe
          flashAddr   <= seqAddr;
          flashCe_b   <= 1'b0;
          flashDqOut  <= seqData;
          flashDqOe_b <= curRead;
          if (cnt_q == 3'd0) begin
            state_q <= S_STROBE;
            cnt_q   <= STROBE_N[2:0];
            if (curRead) begin
              flashOe_b <= 1'b0;
            end else begin
              flashWe_b <= 1'b0;
            end
          end else begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        S_STROBE: begin
          if (cnt_q <= 3'd1) begin
            // Data stays driven past the strobe rise, the earlier rising edge
            flashWe_b <= 1'b1;
            flashOe_b <= 1'b1;
            state_q   <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        S_HOLD: begin
          flashCe_b   <= 1'b1;
          flashDqOe_b <= 1'b1;
          if (curRead) begin
            rdata_q <= dqSync2_q;
          end
          state_q <= S_NEXT;
        end
        S_NEXT: begin
          if (pollMode_q) begin
            state_q <= S_POLL;
          end else if (step_q != lastStep) begin
            step_q  <= step_q + 3'd1;
            state_q <= S_LOAD;
          end else if (ctrl_q[`CTRL_POLL]) begin
            // Poll at the last location; the store output still holds it
            pollMode_q <= 1'b1;
            havePrev_q <= 1'b0;
            toSeen_q   <= 1'b0;
            cnt_q      <= SETUP_N[2:0];
            state_q    <= S_SETUP;
          end else begin
            done_q  <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_POLL: begin
          // Two reads before any verdict; a stopped toggle means done. A
          // timeout flag on two toggling pairs in a row means failure, and
          // software must then issue the reset command
          if (!havePrev_q) begin
            havePrev_q <= 1'b1;
            prevTog_q  <= rdata_q[`TOGGLE1_BIT];
            cnt_q      <= SETUP_N[2:0];
            state_q    <= S_SETUP;
          end else if (rdata_q[`TOGGLE1_BIT] == prevTog_q) begin
            done_q  <= 1'b1;
            state_q <= S_IDLE;
          end else if (rdata_q[`TIMEOUT_BIT] && toSeen_q) begin
            fail_q  <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            toSeen_q  <= rdata_q[`TIMEOUT_BIT];
            prevTog_q <= rdata_q[`TOGGLE1_BIT];
            cnt_q     <= SETUP_N[2:0];
            state_q   <= S_SETUP;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // flash_host_ctrl
`default_nettype wire

/* File: hw/flash_host_map.vh */
// Constants for the flash host controller: register offsets, fields, timing.
// Assumes inclusion by bare name from the controller files.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// Software register offsets (word index on the 4-bit command port)
`define REG_CTRL      4'h0
`define REG_ADDR      4'h1
`define REG_WDATA     4'h2
`define REG_STATUS    4'h3
`define REG_RDATA     4'h4
`define REG_SEQ_IDX   4'h5
`define REG_SEQ_ADDR  4'h6
`define REG_SEQ_DATA  4'h7
// Control register fields
`define CTRL_GO       0
`define CTRL_POLL     1
`define CTRL_LEN_LSB  4
`define CTRL_LEN_MSB  6
`define CTRL_RDMASK_LSB 8
`define CTRL_RDMASK_MSB 13
// Status register fields
`define ST_BUSY       0
`define ST_DONE       1
`define ST_FAIL       2
`define ST_RDY        3
// Reset values
`define CTRL_RST      16'h0000
// Command bytes (upper data byte is don't care in command cycles)
`define CMD_RESET     8'hF0
`define CMD_SEC_ERASE 8'h30
// Bit positions in the status word read back from the device
`define POLL_BIT      7
`define TOGGLE1_BIT   6
`define TIMEOUT_BIT   5
`define WINDOW_BIT    3
`define TOGGLE2_BIT   2
// Bus timing: strobe low and setup times in ns, cycles at 25 ns
`define CLK_NS        25
`define STROBE_NS     50
`define SETUP_NS      25
`define STROBE_CYC    ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC     ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: hw/seq_store.v */
// Small memory holding the address/data words of one command sequence.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/10ps
`default_nettype none
module seq_store (
  input  wire        clk,
  input  wire        wrEn,
  input  wire [2:0]  wrIdx,
  input  wire [21:0] wrAddr,
  input  wire [15:0] wrData,
  input  wire [2:0]  rdIdx,
  output reg  [21:0] rdAddr,
  output reg  [15:0] rdData
);
  reg [21:0] addrMem [0:7];
  reg [15:0] dataMem [0:7];

  // Write port and registered read port
  always @(posedge clk) begin
    if (wrEn) begin
      addrMem[wrIdx] <= wrAddr;
      dataMem[wrIdx] <= wrData;
    end
    rdAddr <= addrMem[rdIdx];
    rdData <= dataMem[rdIdx];
  end
endmodule // seq_store
`default_nettype wire

/* File: verification/flash_dev_model.sv */
// Behavioural flash device seen from its pins.
// Assumes active-low strobes; the model drives the ready line both high and low.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] ID_C = 16'h3C5A  // Arbitrary identifier word
) (
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dqIn,
  input  wire logic        we_b,
  input  wire logic        oe_b,
  input  wire logic        ce_b,
  output logic      [15:0] dqOut,
  output logic             rbDrive_b
);
  logic [21:0] la = 22'h0, progLoc = 22'h0;
  logic [15:0] progVal = 16'h0, q = 16'h0;
  logic [2:0]  bank = 3'h0;
  logic [1:0]  cnt = 2'd0;
  logic        asel = 1'b0, tog = 1'b0, stuck = 1'b0;
  int          busy = 0, idReads = 0;
  wire         wrN = we_b | ce_b;
  wire         rdN = oe_b | ce_b;
  // Location on the later fall, value on the earlier rise
  always @(negedge wrN) la = addr;
  // Command decode on low byte and low address only
  always @(posedge wrN) begin
    if (dqIn[7:0] == 8'hF0) begin
      asel = 1'b0;
      stuck = 1'b0;
      cnt = 2'd0;
    end else if (cnt == 2'd3) begin
      progLoc = la;
      progVal = dqIn;
      // Top location stands for a failing program: toggles with timeout until reset
      stuck = (la == 22'h3FFFFF);
      busy = stuck ? 0 : 4;
      cnt = 2'd0;
    end else if (cnt == 2'd2) begin
      asel = (dqIn[7:0] == 8'h90);
      bank = la[21:19];
      idReads = 0;
      cnt = (dqIn[7:0] == 8'hA0) ? 2'd3 : 2'd0;
    end else if (la[10:0] == (cnt[0] ? 11'h2AA : 11'h555) && dqIn[7:0] == (cnt[0] ? 8'h55 : 8'hAA)) begin
      cnt = cnt + 2'd1;
    end else begin
      cnt = 2'd0;
    end
  end
  // Each read: status while busy, else junk on another bank, ident or array word
  always @(negedge rdN) begin
    if (stuck) begin
      tog = ~tog;
      q = {8'h00, ~progVal[7], tog, 1'b1, 5'h00};
    end else if (busy > 0) begin
      tog = ~tog;
      busy = busy - 1;
      q = {8'h00, ~progVal[7], tog, 6'h00};
    end else if (asel && addr[21:19] != bank) begin
      // A moved bank select answers junk, so the ident check catches it
      q = 16'hFFFF;
    end else if (asel) begin
      idReads = idReads + 1;
      case (addr[7:0])
        8'h0F: q = ID_C;
        8'h03: q = 16'h0081;
        8'h02: q = 16'h0001;
        default: q = 16'h0000;
      endcase
    end else begin
      q = progVal;
    end
  end
  // Released bus shows the inverse, so stale data cannot pass
  assign dqOut = rdN ? ~q : q;
  assign rbDrive_b = (busy > 0 || stuck) ? 1'b0 : 1'b1;
endmodule // flash_dev_model
`default_nettype wire

/* File: verification/flash_host_chk.sv */
// Checker on the flash pins of the host controller.
// Assumes bind to flash_host_ctrl; one clock, async low reset.
`timescale 1ns/10ps
`default_nettype none
module flash_host_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [21:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashDqOe_b,
  input wire logic        flashWe_b,
  input wire logic        flashOe_b,
  input wire logic        flashCe_b
);
  // All pin checks share the controller clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ONE_STROBE: assert property (flashWe_b || flashOe_b)
    else $error("read and write strobes low together");
  AST_DRIVE_WR: assert property (!flashWe_b |-> !flashDqOe_b)
    else $error("write without data driven");
  AST_FREE_RD: assert property (!flashOe_b |-> flashDqOe_b)
    else $error("read with data driven");
  AST_WE_WIDTH: assert property ($fell(flashWe_b) |-> !flashWe_b ##1 !flashWe_b)
    else $error("short write pulse");
  AST_OE_WIDTH: assert property ($fell(flashOe_b) |-> !flashOe_b ##1 !flashOe_b)
    else $error("short read pulse");
  AST_CE_FIRST: assert property ($fell(flashWe_b) |-> $past(!flashCe_b) && $stable(flashAddr))
    else $error("select or location late");
  AST_HOLD: assert property (!flashWe_b && $past(!flashWe_b) |-> $stable({flashAddr, flashDqOut}))
    else $error("location or value moved in pulse");
  AST_CE_DROP: assert property ($rose(flashWe_b) || $rose(flashOe_b) |-> ##[0:2] flashCe_b)
    else $error("select held past cycle");
endmodule // flash_host_chk
bind flash_host_ctrl flash_host_chk u_chk (.clk(clk), .rst_b(rst_b), .flashAddr(flashAddr),
  .flashDqOut(flashDqOut), .flashDqOe_b(flashDqOe_b), .flashWe_b(flashWe_b), .flashOe_b(flashOe_b),
  .flashCe_b(flashCe_b));
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench: host controller against the flash model.
// Assumes the register map header and a ready line driven high and low by the model.
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_map.vh"
module tb;
  localparam logic [15:0] ID3 = 16'h3C5A;
  logic        clk, rst_b, regWr, regRd, readyBusy_n, flashDqOe_b, flashWe_b, flashOe_b, flashCe_b;
  logic [3:0]  regAddr;
  logic [15:0] regWData, regRData, flashDqIn, flashDqOut, st, v;
  logic [21:0] flashAddr, sA [0:7];
  logic [15:0] sD [0:7];
  int          n_mismatch = 0, tests_run = 0, cycles = 0;
  flash_host_ctrl u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
    .regRd(regRd), .regRData(regRData), .flashAddr(flashAddr), .flashDqIn(flashDqIn), .flashDqOut(flashDqOut),
    .flashDqOe_b(flashDqOe_b), .flashWe_b(flashWe_b), .flashOe_b(flashOe_b), .flashCe_b(flashCe_b),
    .readyBusy_n(readyBusy_n));
  flash_dev_model #(.ID_C(ID3)) u_dev (.addr(flashAddr), .dqIn(flashDqOut), .we_b(flashWe_b), .oe_b(flashOe_b),
    .ce_b(flashCe_b), .dqOut(flashDqIn), .rbDrive_b(readyBusy_n));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRData;
  endtask
  // Load the cycle list, start, wait for idle
  task automatic run(input int n, input logic [15:0] ctrl, input logic [15:0] expSt);
    for (int i = 0; i < n; i++) begin
      wr(`REG_SEQ_ADDR, {10'h000, sA[i][21:16]});
      wr(`REG_ADDR, sA[i][15:0]);
      wr(`REG_SEQ_IDX, 16'(i));
      wr(`REG_SEQ_DATA, sD[i]);
    end
    wr(`REG_CTRL, ctrl);
    st = 16'h0001;
    for (int k = 0; k < 300 && st[`ST_BUSY] !== 1'b0; k++) rd(`REG_STATUS, st);
    chk("status", expSt, st & 16'h000F);
  endtask
  task automatic t_reset;
    chk("idlePins", 16'h0001, {15'h0, flashWe_b & flashOe_b & flashCe_b & flashDqOe_b});
    rd(`REG_CTRL, v);
    chk("ctrlReset", `CTRL_RST, v);
    rd(4'hF, v);
    chk("unmapped", 16'h0000, v);
    wr(`REG_WDATA, 16'hC3A5);
    rd(`REG_WDATA, v);
    chk("wdataBack", 16'hC3A5, v);
  endtask
  // Upper data byte of the first unlock is junk on purpose
  task automatic t_program;
    sA = '{0: 22'h3C0555, 1: 22'h2AA, 2: 22'h555, 3: 22'h000C40, default: 22'h0};
    sD = '{0: 16'hFFAA, 1: 16'h0055, 2: 16'h00A0, 3: 16'hA55A, default: 16'h0};
    run(4, 16'h0033, 16'h000A);
    chk("progValue", 16'hA55A, u_dev.progVal);
    chk("progLoc", 16'h0C40, u_dev.progLoc[15:0]);
    rd(`REG_RDATA, v);
    chk("pollData", 16'hA55A, v);
  endtask
  // Bank held at 5 through the autoselect reads
  task automatic t_autoselect;
    sA = '{0: 22'h555, 1: 22'h2AA, 2: 22'h280555, 3: 22'h280001, 4: 22'h28000E, 5: 22'h28000F, default: 22'h0};
    sD = '{0: 16'h00AA, 1: 16'h0055, 2: 16'h0090, 6: 16'h00F0, default: 16'h0};
    run(7, 16'h3861, 16'h000A);
    rd(`REG_RDATA, v);
    chk("idThird", ID3, v);
    chk("idReads", 16'h0003, 16'(u_dev.idReads));
    chk("autoselExit", 16'h0000, {15'h0, u_dev.asel});
  endtask
  // Failing program: toggling with timeout gives fail and busy pin, reset clears
  task automatic t_timeout;
    sA = '{0: 22'h555, 1: 22'h2AA, 2: 22'h555, 3: 22'h3FFFFF, default: 22'h0};
    sD = '{0: 16'h00AA, 1: 16'h0055, 2: 16'h00A0, 3: 16'h0000, default: 16'h0};
    run(4, 16'h0033, 16'h0004);
    sD[0] = 16'h00F0;
    run(1, 16'h0001, 16'h000A);
  endtask
  initial begin
    rst_b = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWData = 16'h0000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_program();
    t_autoselect();
    t_timeout();
    finish_test();
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule // tb
`default_nettype wire
